// *** rx_err_pkg.sv ***
// Shared constants for the receive error status block: register map,
// flag positions, reset values and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package rx_err_pkg;

    // Register byte offsets
    localparam logic [7:0] STATUS_OFS    = 8'h00;
    localparam logic [7:0] IRQ_EN_OFS    = 8'h04;
    localparam logic [7:0] CTRL_OFS      = 8'h08;
    localparam logic [7:0] FRAME_LEN_OFS = 8'h0c;
    localparam logic [7:0] BUFFER_OFS    = 8'h10;

    // Status and enable bit positions
    localparam int OVERRUN_BIT    = 0;
    localparam int EARLY_SYNC_BIT = 1;
    localparam int CLOCK_FAIL_BIT = 2;
    localparam int DMA_ERR_BIT    = 7;
    localparam int ANY_ERR_BIT    = 8;
    localparam int ENABLE_BIT     = 0;

    // Sticky flags that software may clear and enable
    localparam logic [31:0] FLAG_MASK = 32'h0000_0087;

    // Widths
    localparam int WORD_BITS      = 32;
    localparam int FRAME_LEN_BITS = 9;
    localparam int FILL_BITS      = 5;

    // Reset values
    localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
    localparam logic [31:0] IRQ_EN_RESET    = 32'h0000_0000;
    localparam logic        ENABLE_RESET    = 1'b0;
    localparam logic [8:0]  FRAME_LEN_RESET = 9'h040;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rx_link_if.sv ***
// Carrier for the sampled receive link between the pin sampler and
// the deserializer; all signals are on aclk.
`timescale 1ns/100ps
interface rx_link_if;
    logic bit_strobe;   // One-cycle pulse per rising link clock edge
    logic sync_bit;     // Frame sync level at that edge
    logic data_bit;     // Serial data level at that edge

    modport sampler (output bit_strobe, output sync_bit, output data_bit);
    modport deser   (input bit_strobe, input sync_bit, input data_bit);
endinterface

// *** link_sampler.sv ***
// Brings the receive link pins into the aclk domain and finds the
// rising edges of the link clock.
// Assumes the link clock runs well below half the aclk rate.
`timescale 1ns/100ps
module link_sampler (
    // Clock, reset, enable
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   ce,
    // Link pins, asynchronous to aclk
    input  wire logic   rx_link_clk,
    input  wire logic   rx_frame_sync,
    input  wire logic   rx_data_pin,
    // Sampled link
    rx_link_if.sampler  link
);

    typedef struct packed {
        logic [1:0] clk_sync;
        logic [1:0] fs_sync;
        logic [1:0] dat_sync;
        logic       clk_last;
    } sampler_s;

    sampler_s r;
    sampler_s next_r;

    // Two-stage synchronisers; bit 0 is read only by bit 1
    always_comb
    begin
        next_r          = r;
        next_r.clk_sync = {r.clk_sync[0], rx_link_clk};
        next_r.fs_sync  = {r.fs_sync[0], rx_frame_sync};
        next_r.dat_sync = {r.dat_sync[0], rx_data_pin};
        next_r.clk_last = r.clk_sync[1];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else if (ce)
            r <= next_r;
    end

    // Data and sync are taken at the link clock's rising edge
    assign link.bit_strobe = ce & r.clk_sync[1] & ~r.clk_last;
    assign link.sync_bit   = r.fs_sync[1];
    assign link.data_bit   = r.dat_sync[1];

endmodule

// *** rx_deserializer.sv ***
// Receive shift register and frame timing: assembles 32-bit words and
// flags a frame sync that arrives before the frame length has run out.
// Assumes the sampled link from link_sampler on the same clock.
`timescale 1ns/100ps
module rx_deserializer (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // Configuration
    input  wire logic        enable,
    input  wire logic [8:0]  frame_len,
    // Sampled link
    rx_link_if.deser         link,
    // Results
    output logic             word_valid,
    output logic [31:0]      word,
    output logic             early_sync
);

    typedef struct packed {
        logic        in_frame;
        logic [8:0]  bit_cnt;
        logic [4:0]  fill;
        logic [31:0] rx_shift_reg;
        logic [31:0] word;
        logic        word_valid;
        logic        early;
    } deser_s;

    deser_s r;
    deser_s next_r;

    // Frame tracking and word assembly on each rising link clock edge
    always_comb
    begin
        logic [31:0] shifted;
        shifted           = {r.rx_shift_reg[30:0], link.data_bit};
        next_r            = r;
        next_r.word_valid = 1'b0;
        next_r.early      = 1'b0;
        if (!enable)
        begin
            next_r.in_frame = 1'b0;
            next_r.bit_cnt  = '0;
            next_r.fill     = '0;
        end
        else if (link.bit_strobe)
        begin
            if (link.sync_bit)
            begin
                // A sync before the last bit of the frame is early
                if (r.in_frame && (r.bit_cnt < frame_len - 9'h001))
                    next_r.early = 1'b1;
                next_r.in_frame     = 1'b1;
                next_r.bit_cnt      = '0;
                next_r.fill         = 5'h01;
                next_r.rx_shift_reg = shifted;
            end
            else if (r.in_frame)
            begin
                // Saturate so a missing sync cannot wrap the count
                if (r.bit_cnt != 9'h1ff)
                    next_r.bit_cnt = r.bit_cnt + 9'h001;
                next_r.fill         = r.fill + 5'h01;
                next_r.rx_shift_reg = shifted;
                if (r.fill == 5'h1f)
                begin
                    next_r.word       = shifted;
                    next_r.word_valid = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else if (ce)
            r <= next_r;
    end

    assign word_valid = r.word_valid;
    assign word       = r.word;
    assign early_sync = r.early;

endmodule

// *** rx_error_status_flags.sv ***
// Receive error status block: sticky error flags, interrupt enables,
// receive buffer and an AXI4-Lite slave for software access.
// Assumes clock-fail and DMA-error events are one-cycle pulses on aclk.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module rx_error_status_flags (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Receive link pins
    input  wire logic        rx_link_clk,
    input  wire logic        rx_frame_sync,
    input  wire logic        rx_data_pin,
    // Error events from neighbouring logic on aclk
    input  wire logic        clock_fail_event,
    input  wire logic        dma_error_event,
    // Interrupt
    output logic             rx_interrupt
);

    typedef struct packed {
        logic [31:0] rx_status_reg;
        logic [31:0] rx_irq_enable_reg;
        logic        enable;
        logic [8:0]  frame_len;
        logic [31:0] rx_buffer;
        logic        buf_full;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } regs_s;

    localparam regs_s REGS_RESET = '{
        rx_status_reg:     rx_err_pkg::STATUS_RESET,
        rx_irq_enable_reg: rx_err_pkg::IRQ_EN_RESET,
        enable:            rx_err_pkg::ENABLE_RESET,
        frame_len:         rx_err_pkg::FRAME_LEN_RESET,
        default:           '0
    };

    regs_s r;
    regs_s next_r;

    rx_link_if link ();

    logic        word_valid;
    logic [31:0] word;
    logic        early_sync;

    // Merge written bytes into an old value under the byte strobes
    function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = new_val[i*8 +: 8];
        return res;
    endfunction

    // True for any byte address that holds a register
    function automatic logic is_mapped(input logic [7:0] addr);
        return (addr == rx_err_pkg::STATUS_OFS) || (addr == rx_err_pkg::IRQ_EN_OFS) ||
               (addr == rx_err_pkg::CTRL_OFS) || (addr == rx_err_pkg::FRAME_LEN_OFS) ||
               (addr == rx_err_pkg::BUFFER_OFS);
    endfunction

    link_sampler u_sampler (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .rx_link_clk   (rx_link_clk),
        .rx_frame_sync (rx_frame_sync),
        .rx_data_pin   (rx_data_pin),
        .link          (link.sampler)
    );

    rx_deserializer u_deser (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .enable     (r.enable),
        .frame_len  (r.frame_len),
        .link       (link.deser),
        .word_valid (word_valid),
        .word       (word),
        .early_sync (early_sync)
    );

    // Readies drop while frozen so no handshake is lost
    assign awready = ce & ~r.aw_held & ~r.bvalid;
    assign wready  = ce & ~r.w_held & ~r.bvalid;
    assign arready = ce & ~r.rvalid;

    // Register state update
    always_comb
    begin
        logic [31:0] events;
        logic [31:0] clear;
        logic [31:0] wr_val;
        logic        buf_read;
        logic        do_write;
        logic        any_err;
        next_r   = r;
        events   = '0;
        clear    = '0;
        wr_val   = '0;
        buf_read = 1'b0;
        do_write = r.aw_held & r.w_held & ~r.bvalid;
        any_err  = |(r.rx_status_reg & rx_err_pkg::FLAG_MASK);

        // Read channel; a buffer read empties the buffer
        if (arvalid && arready)
        begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = is_mapped(araddr) ? rx_err_pkg::RESP_OKAY : rx_err_pkg::RESP_SLVERR;
            next_r.rdata  = '0;
            unique case (araddr)
                rx_err_pkg::STATUS_OFS:
                begin
                    next_r.rdata = r.rx_status_reg & rx_err_pkg::FLAG_MASK;
                    next_r.rdata[rx_err_pkg::ANY_ERR_BIT] = any_err;
                end
                rx_err_pkg::IRQ_EN_OFS:
                    next_r.rdata = r.rx_irq_enable_reg;
                rx_err_pkg::CTRL_OFS:
                    next_r.rdata[rx_err_pkg::ENABLE_BIT] = r.enable;
                rx_err_pkg::FRAME_LEN_OFS:
                    next_r.rdata[8:0] = r.frame_len;
                rx_err_pkg::BUFFER_OFS:
                begin
                    next_r.rdata = r.rx_buffer;
                    buf_read     = 1'b1;
                end
                default:
                    next_r.rdata = '0;
            endcase
        end
        else if (r.rvalid && rready)
            next_r.rvalid = 1'b0;

        // Write address and data may arrive in either order
        if (awvalid && awready)
        begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_r.w_held = 1'b1;
            next_r.w_data = wdata;
            next_r.w_strb = wstrb;
        end

        // Perform the write once both halves are held
        if (do_write)
        begin
            next_r.aw_held = 1'b0;
            next_r.w_held  = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = rx_err_pkg::RESP_OKAY;
            unique case (r.aw_addr)
                rx_err_pkg::STATUS_OFS:
                    clear = apply_strb('0, r.w_data, r.w_strb) & rx_err_pkg::FLAG_MASK;
                rx_err_pkg::IRQ_EN_OFS:
                    next_r.rx_irq_enable_reg = apply_strb(r.rx_irq_enable_reg, r.w_data, r.w_strb)
                                               & rx_err_pkg::FLAG_MASK;
                rx_err_pkg::CTRL_OFS:
                begin
                    wr_val        = apply_strb({31'h0, r.enable}, r.w_data, r.w_strb);
                    next_r.enable = wr_val[rx_err_pkg::ENABLE_BIT];
                end
                rx_err_pkg::FRAME_LEN_OFS:
                begin
                    wr_val           = apply_strb({23'h0, r.frame_len}, r.w_data, r.w_strb);
                    next_r.frame_len = wr_val[8:0];
                end
                default:
                    next_r.bresp = rx_err_pkg::RESP_SLVERR; // Buffer is read-only
            endcase
        end
        else if (r.bvalid && bready)
            next_r.bvalid = 1'b0;

        // Receive buffer: a new word overwrites, so the newest data wins
        if (word_valid)
        begin
            next_r.rx_buffer = word;
            next_r.buf_full  = 1'b1;
        end
        else if (buf_read)
            next_r.buf_full = 1'b0;

        // Error events
        events[rx_err_pkg::OVERRUN_BIT]    = word_valid & r.buf_full & ~buf_read;
        events[rx_err_pkg::EARLY_SYNC_BIT] = early_sync;
        events[rx_err_pkg::CLOCK_FAIL_BIT] = clock_fail_event;
        events[rx_err_pkg::DMA_ERR_BIT]    = dma_error_event;

        // Sticky flags; a set in the clearing cycle survives
        next_r.rx_status_reg = (r.rx_status_reg & ~clear) | events;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= REGS_RESET;
        else if (ce)
            r <= next_r;
    end

    // Level interrupt straight from the flag and enable registers
    assign rx_interrupt = |(r.rx_status_reg & r.rx_irq_enable_reg & rx_err_pkg::FLAG_MASK);

    // Bus outputs come from flip-flops
    assign bvalid = r.bvalid;
    assign bresp  = r.bresp;
    assign rvalid = r.rvalid;
    assign rresp  = r.rresp;
    assign rdata  = r.rdata;

endmodule

// *** rx_error_status_flags_chk.sv ***
// Bus handshake and interrupt checks for the receive error status block.
// Assumes it is bound to the block and sees only the block's ports.
`timescale 1ns/100ps
module rx_error_status_flags_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    // Events and interrupt
    input wire logic        clock_fail_event,
    input wire logic        ce,
    input wire logic        rx_interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Answers stand until the master takes them
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    // Fixed answer latencies from the hand-over timing
    property p_rd_ans;
        arvalid && arready |=> rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_wr_ans;
        awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer not on time");
    // One access of each kind in flight
    property p_ar_block;
        rvalid |-> !arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");
    property p_aw_block;
        bvalid |-> !awready && !wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write accepted while busy");
    // Interrupt only falls when a register write lands
    property p_irq_fall;
        $fell(rx_interrupt) && $past(aresetn) |-> $rose(bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without write");
    // No write pending, so a fresh event must keep the interrupt up
    property p_irq_keep;
        clock_fail_event && ce && rx_interrupt && awready && wready |=> rx_interrupt;
    endproperty
    a_irq_keep: assert property (p_irq_keep) else $error("flag lost on event");
endmodule

bind rx_error_status_flags rx_error_status_flags_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .clock_fail_event(clock_fail_event), .ce(ce), .rx_interrupt(rx_interrupt)
);

// *** rx_source.sv ***
// Model of the audio source that drives the receive link pins.
// Assumes the bench calls frame(); link clock is still between calls.
`timescale 1ns/100ps
module rx_source (
    // Link pins
    output logic link_clk,
    output logic frame_sync,
    output logic data
);
    // Idle levels at time zero
    initial
    begin
        link_clk = 1'b0;
        frame_sync = 1'b0;
        data = 1'b0;
    end

    // Sends n bits MSB first from d[63], sync with the first; 80 ns period
    task automatic frame(input int n, input logic [63:0] d);
        for (int i = 0; i < n; i++)
        begin
            frame_sync = (i == 0);
            data = d[63 - i];
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        // Released lines show the inverse so stale bits cannot pass
        frame_sync = ~frame_sync;
        data = ~data;
    endtask
endmodule

// *** rx_error_status_flags_tb.sv ***
// Self-checking bench for the receive error status block.
// Assumes the block, its checker and the link source model are compiled first.
`timescale 1ns/100ps
module rx_error_status_flags_tb;
    localparam logic [7:0] ST = rx_err_pkg::STATUS_OFS;
    localparam logic [7:0] EN = rx_err_pkg::IRQ_EN_OFS;
    localparam logic [7:0] BF = rx_err_pkg::BUFFER_OFS;
    localparam logic [1:0] OK = rx_err_pkg::RESP_OKAY;
    localparam logic [1:0] SE = rx_err_pkg::RESP_SLVERR;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        cfe = 1'b0;
    logic        dme = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, lclk, fsync, sdata;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    rx_error_status_flags DUT (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_link_clk(lclk), .rx_frame_sync(fsync), .rx_data_pin(sdata),
        .clock_fail_event(cfe), .dma_error_event(dme), .rx_interrupt(irq)
    );
    rx_source src (.link_clk(lclk), .frame_sync(fsync), .data(sdata));

    // 100 MHz clock and a hang guard
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done;
        $display("errors %0d, compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write: offer both halves, drop each when taken, then wait the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw)
        begin
            @(posedge aclk);
            if (pa && awready)
            begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready)
            begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        // A late bready makes the response stand for a cycle
        repeat (2) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        // A late rready makes the read data stand for a cycle
        @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, d);
        chk({30'h0, rresp}, {30'h0, r});
    endtask

    // One-cycle event pulse: clock failure if c, else DMA error
    task automatic pulse(input logic c);
        @(posedge aclk);
        cfe <= c;
        dme <= !c;
        @(posedge aclk);
        cfe <= 1'b0;
        dme <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ST, 32'h0, OK);
        rd(EN, 32'h0, OK);
        rd(rx_err_pkg::FRAME_LEN_OFS, {23'h0, rx_err_pkg::FRAME_LEN_RESET}, OK);
        rd(8'h20, 32'h0, SE);
        rd(8'h02, 32'h0, SE);
        wr(BF, 32'h1, SE);
        pulse(1'b1);
        rd(ST, 32'h104, OK);
        wr(EN, 32'h4, OK);
        chk({31'h0, irq}, 32'h1);
        pulse(1'b1);
        chk({31'h0, irq}, 32'h1);
        wr(ST, 32'h0, OK);
        rd(ST, 32'h104, OK);
        // Clear and a new clock-fail report land on the same edge
        fork
            wr(ST, 32'h4, OK);
            begin
                @(posedge aclk);
                cfe <= 1'b1;
                @(posedge aclk);
                cfe <= 1'b0;
            end
        join
        rd(ST, 32'h104, OK);
        pulse(1'b0);
        rd(ST, 32'h184, OK);
        wr(EN, 32'h0, OK);
        chk({31'h0, irq}, 32'h0);
        // Two words without a read, then a sync on time
        wr(rx_err_pkg::CTRL_OFS, 32'h1, OK);
        src.frame(64, 64'h8123_4567_9abc_def0);
        src.frame(10, 64'h0);
        repeat (10) @(posedge aclk);
        rd(ST, 32'h185, OK);
        src.frame(1, 64'h0);
        repeat (10) @(posedge aclk);
        rd(ST, 32'h187, OK);
        rd(BF, 32'h9abc_def0, OK);
        // Each flag alone raises the interrupt; clearing drops it
        for (int b = 0; b < 4; b++)
        begin
            wr(EN, 32'h1 << ((b == 3) ? 7 : b), OK);
            chk({31'h0, irq}, 32'h1);
            wr(ST, 32'h1 << ((b == 3) ? 7 : b), OK);
            chk({31'h0, irq}, 32'h0);
        end
        rd(ST, 32'h0, OK);
        // Reports while frozen are ignored
        ce <= 1'b0;
        pulse(1'b1);
        ce <= 1'b1;
        rd(ST, 32'h0, OK);
        test_done();
    end
endmodule
